// ==== logic/reset_ctrl_regs.svh ====
`ifndef RESET_CTRL_REGS_SVH
`define RESET_CTRL_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADR_CAUSE      12'hFF0
`define ADR_WDCTL      12'hFF4
`define ADR_SMREN      12'hFF8
`define ADR_DBGCTL     12'hFFC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_POR        7
`define BIT_STOP       6
`define BIT_WDT        5
`define BIT_EXT        4
`define BIT_DBG_RST    0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SMREN      8'h00
`define RST_VECTOR     16'h0002

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  25
`define STARTUP_NS     4000
`define STARTUP_CYC    ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_IPO_CYC   66
`define HOLD_XTAL_CYC  5000
`define PIN_FILTER_CYC 3

`endif

// ==== logic/rst_ctrl_pkg.sv ====
package rst_ctrl_pkg;

    // sequencer phases
    typedef enum logic [2:0] {
        ST_RUN,
        ST_SUPPLY,
        ST_START,
        ST_HOLD,
        ST_PIN
    } rst_state_t;

    // system reset or stop-mode recovery
    typedef enum logic {
        KIND_SYS,
        KIND_SMR
    } rst_kind_t;

    // latched origin of the reset in progress
    typedef struct packed {
        logic por;
        logic wdt;
        logic external_reset_flag;
        logic dbg;
    } cause_t;

endpackage

// ==== logic/sync_two_ff.sv ====
module sync_two_ff #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    // the first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_ff <= INIT;
            q_ff    <= INIT;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

// ==== logic/pin_deglitch.sv ====
`include "reset_ctrl_regs.svh"
module pin_deglitch #(
    parameter int LEN = `PIN_FILTER_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic in_n,
    output logic      req
);
    logic [3:0] run_ff;
    logic       req_ff;

    if (LEN < `PIN_FILTER_CYC || LEN > 15) begin : g_bad_len
        $error("pin_deglitch: LEN out of range");
    end

    // count consecutive low samples, saturating at LEN
    always_ff @(posedge ref_clk) begin
        if (rst || in_n) begin
            run_ff <= 4'h0;
        end else if (run_ff != 4'(LEN)) begin
            run_ff <= run_ff + 4'h1;
        end
    end

    // shorter pulses never reach the count and are dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= !in_n && (run_ff >= 4'(LEN - 1)); // RL15 RL20
        end
    end

    assign req = req_ff;

    a_filter_len: assert property (@(posedge ref_clk) disable iff (rst) // RL15
        req_ff |-> !$past(in_n, 1) && !$past(in_n, 2) && !$past(in_n, 3))
        else $error("pin request without three low samples");
endmodule

// ==== logic/reset_and_stop_recovery_ctrl.sv ====
// Added by the designer: the Wishbone register port.
`include "reset_ctrl_regs.svh"
// Function
// RL1 - system reset from supply, watchdog, pin, debugger
// RL2 - stop mode recovers on watchdog or gpio edge
// RL3 - brownout always forces reset
// RL4 - hold 66 oscillator cycles without crystal
// RL5 - hold 5000 oscillator cycles with crystal
// RL6 - wait oscillator startup before counting
// RL7 - recovery resets cpu, keeps most registers
// RL8 - supply resets count after supply recovers
// RL9 - stay in reset while pin low
// RL10 - gpio inputs without pull-ups at reset
// RL11 - oscillators keep running during reset
// RL12 - load defined reset values into registers
// RL13 - cpu fetches vector at 0002h/0003h
// RL14 - internal oscillator selected after reset
// RL15 - ignore pin pulses under three clocks
// RL16 - debugger reset spares the debugger
// RL17 - stop mode system reset sources, filtered
// RL18 - set power-on flag after power reset
// RL19 - set pin flag after pin reset
// RL20 - four-cycle pin pulse always recognised
// RL21 - set stop flag after recovery
// RL22 - synchronise asynchronous inputs first
// RL23 - new request restarts the hold count
module reset_and_stop_recovery_ctrl #(
    parameter int GPIO_W        = 8,
    parameter int IPO_DIV       = 1,
    parameter int XTAL_HOLD_CYC = `HOLD_XTAL_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              por_ok_a,
    input  wire logic              bor_ok_a,
    input  wire logic              ext_rst_n_a,
    input  wire logic              debug_pin_n_a,
    input  wire logic [GPIO_W-1:0] gpio_a,
    input  wire logic              wdt_timeout,
    input  wire logic              stop_mode,
    input  wire logic              opt_xtal_en,
    input  wire logic              opt_wdt_reset,
    input  wire logic              ext_alt_en,
    output logic                   cpu_reset,
    output logic                   periph_reset,
    output logic                   debugger_reset,
    output logic                   ctl_load,
    output logic                   wdt_osc_load,
    output logic                   gpio_default,
    output logic                   fetch_vector,
    output logic      [15:0]       vector_addr,
    output logic                   osc_run,
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe_n
);
    import rst_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (IPO_DIV < 1 || IPO_DIV > 8) begin : g_bad_div
        $error("IPO_DIV out of range");
    end
    if (XTAL_HOLD_CYC < 1 || XTAL_HOLD_CYC > 8191) begin : g_bad_hold
        $error("XTAL_HOLD_CYC out of range");
    end
    if (GPIO_W < 1 || GPIO_W > 8) begin : g_bad_gpio
        $error("GPIO_W out of range");
    end

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    logic [GPIO_W+3:0] async_in;
    logic [GPIO_W+3:0] sync_out;
    logic [GPIO_W-1:0] gpio_s;
    logic              por_ok;
    logic              bor_ok;
    logic              ext_pin_s;
    logic              debug_pin_s;
    logic              ext_req;

    assign async_in = {gpio_a, debug_pin_n_a, ext_rst_n_a, bor_ok_a, por_ok_a};

    // idle levels at reset: supply bad, pins released
    sync_two_ff #(
        .WIDTH (GPIO_W + 4),
        .INIT  ({{GPIO_W{1'b0}}, 4'hC})
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (async_in),
        .q       (sync_out)
    ); // RL22

    assign por_ok      = sync_out[0];
    assign bor_ok      = sync_out[1];
    assign ext_pin_s   = sync_out[2];
    assign debug_pin_s = sync_out[3];
    assign gpio_s      = sync_out[GPIO_W+3:4];

    pin_deglitch #(
        .LEN (`PIN_FILTER_CYC)
    ) u_pin_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .in_n    (ext_pin_s),
        .req     (ext_req)
    ); // RL15 RL17

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    rst_state_t        state_ff;
    rst_state_t        nxt_state;
    rst_kind_t         kind_ff;
    rst_kind_t         nxt_kind;
    cause_t            cause_ff;
    cause_t            nxt_cause;
    logic [12:0]       cnt_ff;
    logic [12:0]       nxt_cnt;
    logic [2:0]        div_ff;
    logic              sys_req_d_ff;
    logic [GPIO_W-1:0] gpio_prev_ff;
    logic [7:0]        flags_ff;
    logic [7:0]        nxt_flags;
    logic [GPIO_W-1:0] smren_ff;
    logic              dbg_rst_ff;
    logic              ack_ff;
    logic [31:0]       rdata_ff;

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    cause_t      src;
    logic        supply_ok;
    logic        sys_req;
    logic        sys_evt;
    logic        gpio_edge;
    logic        smr_req;
    logic        ipo_tick;
    logic [12:0] hold_target;
    logic        busy_nxt;
    logic        sys_nxt;
    logic        release_now;
    logic        start_now;
    logic        sys_start;

    // brownout and power-on share the supply path
    assign supply_ok   = por_ok && bor_ok; // RL3 RL8
    assign src.por     = !supply_ok;
    assign src.wdt     = wdt_timeout && opt_wdt_reset && !stop_mode;
    assign src.external_reset_flag     = ext_alt_en && ext_req;
    assign src.dbg     = dbg_rst_ff || (stop_mode && !debug_pin_s); // RL17
    assign sys_req     = |src; // RL1
    assign sys_evt     = sys_req && !sys_req_d_ff;
    assign gpio_edge   = |((gpio_s ^ gpio_prev_ff) & smren_ff);
    assign smr_req     = stop_mode && (wdt_timeout || gpio_edge); // RL2
    assign ipo_tick    = (div_ff == 3'(IPO_DIV - 1));
    assign hold_target = opt_xtal_en ? 13'(XTAL_HOLD_CYC) : 13'(`HOLD_IPO_CYC); // RL4 RL5
    assign busy_nxt    = (nxt_state != ST_RUN);
    assign sys_nxt     = busy_nxt && (nxt_kind == KIND_SYS);
    assign release_now = (state_ff != ST_RUN) && !busy_nxt;
    assign start_now   = (state_ff == ST_RUN) && busy_nxt;
    assign sys_start   = sys_nxt && ((state_ff == ST_RUN) || (kind_ff == KIND_SMR) || sys_evt);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // the pin is still watched during reset so a new press restarts the count
    always_comb begin
        nxt_state = state_ff;
        nxt_kind  = kind_ff;
        nxt_cause = cause_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_RUN: begin
                if (sys_req) begin
                    nxt_state = supply_ok ? ST_START : ST_SUPPLY; // RL1
                    nxt_kind  = KIND_SYS;
                    nxt_cause = src;
                    nxt_cnt   = 13'h0000;
                end else if (smr_req) begin
                    nxt_state = ST_START; // RL2
                    nxt_kind  = KIND_SMR;
                    nxt_cause = '{por: 1'b0, wdt: wdt_timeout, external_reset_flag: 1'b0, dbg: 1'b0};
                    nxt_cnt   = 13'h0000;
                end
            end
            ST_SUPPLY: begin
                if (supply_ok) begin
                    nxt_state = ST_START; // RL8
                    nxt_cnt   = 13'h0000;
                end
            end
            ST_START: begin
                if (cnt_ff == 13'(`STARTUP_CYC - 1)) begin
                    nxt_state = ST_HOLD; // RL6
                    nxt_cnt   = 13'h0000;
                end else begin
                    nxt_cnt = cnt_ff + 13'h0001;
                end
            end
            ST_HOLD: begin
                if (ipo_tick && cnt_ff == hold_target - 13'h0001) begin
                    nxt_state = (ext_alt_en && !ext_pin_s) ? ST_PIN : ST_RUN; // RL9
                end else if (ipo_tick) begin
                    nxt_cnt = cnt_ff + 13'h0001; // RL4 RL5
                end
            end
            ST_PIN: begin
                if (ext_pin_s) begin
                    nxt_state = ST_RUN; // RL9
                end
            end
            default: begin
                nxt_state = ST_SUPPLY;
            end
        endcase
        if (state_ff != ST_RUN && !supply_ok) begin
            nxt_state = ST_SUPPLY; // RL8
            nxt_kind  = KIND_SYS;
            nxt_cause = cause_ff | src;
            nxt_cnt   = 13'h0000;
        end else if (state_ff != ST_RUN && sys_evt) begin
            nxt_state = ST_START; // RL23
            nxt_kind  = KIND_SYS;
            nxt_cause = cause_ff | src;
            nxt_cnt   = 13'h0000;
        end
    end

    // block reset enters a full power-on sequence
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= ST_SUPPLY;
            kind_ff  <= KIND_SYS;
            cause_ff <= '{por: 1'b1, wdt: 1'b0, external_reset_flag: 1'b0, dbg: 1'b0};
            cnt_ff   <= 13'h0000;
        end else begin
            state_ff <= nxt_state;
            kind_ff  <= nxt_kind;
            cause_ff <= nxt_cause;
            cnt_ff   <= nxt_cnt;
        end
    end

    // oscillator tick divider, phase restarted on entry to the hold
    always_ff @(posedge ref_clk) begin
        if (rst || state_ff != ST_HOLD || ipo_tick) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    // edge history for requests and recovery pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sys_req_d_ff <= 1'b1; // supply reads bad after reset, so no false request edge
            gpio_prev_ff <= '0;
        end else begin
            sys_req_d_ff <= sys_req;
            gpio_prev_ff <= gpio_s;
        end
    end

    // ----------------------------------------------------------------
    // status flags and control registers
    // ----------------------------------------------------------------
    logic       wb_hit;
    logic       wr_lane;
    logic       wr_wdctl;
    logic       wr_smren;
    logic       wr_dbg;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;
    logic [7:0] rd_byte;

    assign wb_hit   = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lane  = wb_hit && wb_we_i && wb_sel_i[0];
    assign wr_wdctl = wr_lane && (wb_adr_i == `ADR_WDCTL);
    assign wr_smren = wr_lane && (wb_adr_i == `ADR_SMREN);
    assign wr_dbg   = wr_lane && (wb_adr_i == `ADR_DBGCTL);

    // flags are posted at release; a set beats a clear in the same cycle
    always_comb begin
        set_mask                = 8'h00;
        set_mask[`BIT_POR]      = release_now && (cause_ff.por || cause_ff.dbg); // RL18
        set_mask[`BIT_EXT]      = release_now && cause_ff.external_reset_flag; // RL19
        set_mask[`BIT_WDT]      = release_now && cause_ff.wdt;
        set_mask[`BIT_STOP]     = release_now && (kind_ff == KIND_SMR); // RL21
        clr_mask                = wr_wdctl ? wb_dat_i[7:0] : 8'h00;
        nxt_flags               = (flags_ff & ~clr_mask) | set_mask;
    end

    assign rd_byte = (wb_adr_i == `ADR_CAUSE)  ? flags_ff :
                     (wb_adr_i == `ADR_WDCTL)  ? flags_ff :
                     (wb_adr_i == `ADR_SMREN)  ? 8'(smren_ff) :
                     (wb_adr_i == `ADR_DBGCTL) ? 8'(dbg_rst_ff) : 8'h00;

    // flags survive system resets; only the block reset or a write to WDCTL clears them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_ff <= 8'h00;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // recovery enables take their default on every system reset
    always_ff @(posedge ref_clk) begin
        if (rst || sys_start) begin
            smren_ff <= GPIO_W'(`RST_SMREN); // RL12 RL7
        end else if (wr_smren) begin
            smren_ff <= wb_dat_i[GPIO_W-1:0];
        end
    end

    // debugger request clears itself once the system reset is under way
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dbg_rst_ff <= 1'b0;
        end else if (wr_dbg) begin
            dbg_rst_ff <= wb_dat_i[`BIT_DBG_RST]; // RL1
        end else if (state_ff != ST_RUN && kind_ff == KIND_SYS) begin
            dbg_rst_ff <= 1'b0;
        end
    end

    // single-cycle ack; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= wb_hit;
            rdata_ff <= wb_hit ? {24'h00_0000, rd_byte} : rdata_ff;
        end
    end

    // ----------------------------------------------------------------
    // reset outputs
    // ----------------------------------------------------------------
    logic cpu_reset_ff;
    logic periph_reset_ff;
    logic debugger_reset_ff;
    logic ctl_load_ff;
    logic wdt_osc_load_ff;
    logic gpio_default_ff;
    logic fetch_vector_ff;
    logic rst_pin_oe_n_ff;

    // a debugger-started reset never touches the debugger itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_reset_ff      <= 1'b1;
            periph_reset_ff   <= 1'b1;
            debugger_reset_ff <= 1'b1;
            ctl_load_ff       <= 1'b1;
            wdt_osc_load_ff   <= 1'b1;
            gpio_default_ff   <= 1'b1;
            fetch_vector_ff   <= 1'b0;
            rst_pin_oe_n_ff   <= 1'b0;
        end else begin
            cpu_reset_ff      <= busy_nxt; // RL7
            periph_reset_ff   <= sys_nxt; // RL7
            debugger_reset_ff <= sys_nxt && nxt_cause.por; // RL16
            ctl_load_ff       <= sys_start; // RL12
            wdt_osc_load_ff   <= start_now || sys_start; // RL14 RL7
            gpio_default_ff   <= busy_nxt; // RL10
            fetch_vector_ff   <= release_now; // RL13
            rst_pin_oe_n_ff   <= !sys_nxt;
        end
    end

    assign cpu_reset      = cpu_reset_ff;
    assign periph_reset   = periph_reset_ff;
    assign debugger_reset = debugger_reset_ff;
    assign ctl_load       = ctl_load_ff;
    assign wdt_osc_load   = wdt_osc_load_ff;
    assign gpio_default   = gpio_default_ff;
    assign fetch_vector   = fetch_vector_ff;
    assign rst_pin_oe_n   = rst_pin_oe_n_ff;
    assign wb_ack_o       = ack_ff;
    assign wb_dat_o       = rdata_ff;

    // constant-valued outputs still come from flops
    logic [15:0] vector_ff;
    logic        osc_run_ff;
    logic        pin_low_ff;

    always_ff @(posedge ref_clk) begin
        vector_ff  <= `RST_VECTOR; // RL13
        osc_run_ff <= 1'b1; // RL11
        pin_low_ff <= 1'b0;
    end

    assign vector_addr = vector_ff;
    assign osc_run     = osc_run_ff;
    assign rst_pin_o   = pin_low_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [15:0] obs_ff;

    always_ff @(posedge ref_clk) begin
        if (rst || nxt_state != state_ff || sys_evt) begin
            obs_ff <= 16'h0000;
        end else begin
            obs_ff <= obs_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_smr_release;
        kind_ff == KIND_SMR && state_ff != ST_RUN ##1 state_ff == ST_RUN;
    endsequence

    sequence s_por_release;
        cause_ff.por && state_ff != ST_RUN ##1 state_ff == ST_RUN;
    endsequence

    a_sys_start: assert property ( // RL1
        state_ff == ST_RUN && sys_req |=> cpu_reset_ff && periph_reset_ff)
        else $error("system request did not start reset");
    a_smr_start: assert property ( // RL2
        state_ff == ST_RUN && !sys_req && smr_req |=> cpu_reset_ff && !periph_reset_ff)
        else $error("recovery did not start correctly");
    a_bor_hold: assert property ( // RL3
        !bor_ok |=> state_ff == ST_SUPPLY && cpu_reset_ff)
        else $error("brownout did not hold reset");
    a_hold_len: assert property ( // RL4 RL5
        state_ff == ST_HOLD && (nxt_state == ST_RUN || nxt_state == ST_PIN)
        |-> obs_ff == 16'(int'(hold_target) * IPO_DIV - 1))
        else $error("hold length wrong");
    a_startup_len: assert property ( // RL6
        state_ff == ST_START && nxt_state == ST_HOLD |-> obs_ff == 16'(`STARTUP_CYC - 1))
        else $error("startup wait wrong");
    a_supply_wait: assert property ( // RL8
        state_ff != ST_RUN && !supply_ok |=> state_ff == ST_SUPPLY [*1] ##0 cnt_ff == 13'h0000)
        else $error("count ran with supply low");
    a_pin_stay: assert property ( // RL9
        state_ff == ST_PIN && !ext_pin_s |=> cpu_reset_ff && state_ff == ST_PIN)
        else $error("left reset with pin low");
    a_stop_flag: assert property ( // RL21
        s_smr_release |-> flags_ff[`BIT_STOP] && fetch_vector_ff ##1 !fetch_vector_ff)
        else $error("stop flag or vector fetch missing");
    a_por_flag: assert property ( // RL18
        s_por_release |-> flags_ff[`BIT_POR])
        else $error("power-on flag missing");
    a_dbg_spared: assert property ( // RL16
        state_ff == ST_RUN && dbg_rst_ff && supply_ok |=> !debugger_reset_ff && cpu_reset_ff)
        else $error("debugger reset by its own request");
endmodule

// ==== verification/cpu_partner.sv ====
module cpu_partner (
    input  wire logic        ref_clk,
    input  wire logic        cpu_reset,
    input  wire logic        fetch_vector,
    input  wire logic [15:0] vector_addr,
    output int               n_fetch,
    output int               n_bad
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        n_fetch = 0;
        n_bad = 0;
    end
    // the core stays idle in reset and starts once, from the fixed vector
    always @(posedge ref_clk) begin
        if (fetch_vector === 1'b1) begin
            n_fetch <= n_fetch + 1;
            if (vector_addr !== 16'h0002 || cpu_reset !== 1'b0) n_bad <= n_bad + 1;
        end
    end
endmodule

// ==== verification/reset_and_stop_recovery_ctrl_test.sv ====
module reset_and_stop_recovery_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 0, rst = 1, cyc = 0, we = 0, wdt = 0, stp = 0, xt = 0, wdr = 0;
    logic        por = 0, bor = 1, ext_n = 1, dbg_n = 1, alt = 1;
    logic [11:0] adr = '0;
    logic [7:0]  dat = '0, rd, gp = '0;
    logic [31:0] dat_o;
    logic        ack, cpu_reset, periph_reset, dbg_rst, fv, gd, oe_n, cl, wl, osc, po;
    logic [15:0] va;
    int          mismatches = 0, n_checks = 0, nf, nb;

    reset_and_stop_recovery_ctrl #(.XTAL_HOLD_CYC(20)) DUT (
        .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, dat}), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .por_ok_a(por), .bor_ok_a(bor), .ext_rst_n_a(ext_n),
        .debug_pin_n_a(dbg_n), .gpio_a(gp), .wdt_timeout(wdt), .stop_mode(stp),
        .opt_xtal_en(xt), .opt_wdt_reset(wdr), .ext_alt_en(alt), .cpu_reset(cpu_reset),
        .periph_reset(periph_reset), .debugger_reset(dbg_rst), .ctl_load(cl), .wdt_osc_load(wl),
        .gpio_default(gd), .fetch_vector(fv), .vector_addr(va), .osc_run(osc), .rst_pin_o(po),
        .rst_pin_oe_n(oe_n));
    cpu_partner CPU (.ref_clk(ref_clk), .cpu_reset(cpu_reset), .fetch_vector(fv),
        .vector_addr(va), .n_fetch(nf), .n_bad(nb));

    // -------------------------------------------------
    // clock and hang guard
    // -------------------------------------------------
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        end_of_test();
    end

    // -------------------------------------------------
    // tasks
    // -------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // classic cycle: request held until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        cyc <= 1; we <= w; adr <= a; dat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge ref_clk);
        rd = dat_o[7:0];
        cyc <= 0;
        if (i == 20) begin mismatches++; end_of_test(); end
    endtask
    // waits for entry, checks output set, measures how long cpu_reset stays high
    task automatic run(input int lo, input int hi, input logic [7:0] e);
        int n;
        for (n = 0; n < 40 && cpu_reset !== 1'b1; n++) @(posedge ref_clk);
        chk({periph_reset, gd, oe_n, dbg_rst, cl, wl, osc, po}, e);
        for (n = 0; n < 6000 && cpu_reset === 1'b1; n++) @(posedge ref_clk);
        chk(n >= lo && n <= hi, 1'b1);
        repeat (3) @(posedge ref_clk);
    endtask
    // cause register, then clear through the watchdog control copy
    task automatic flags(input string t, input logic [7:0] e);
        wb(0, 12'hFF0, 0);
        chk(rd, e);
        wb(1, 12'hFF4, 8'hF0);
        $display("test %s done", t);
    endtask
    task automatic hold(input int n, input logic pin);
        if (pin) ext_n <= 0; else dbg_n <= 0;
        repeat (n) @(posedge ref_clk);
        ext_n <= 1;
        dbg_n <= 1;
    endtask
    task automatic pulse();
        wdt <= 1;
        @(posedge ref_clk);
        wdt <= 0;
    endtask

    // -------------------------------------------------
    // scenarios
    // -------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        repeat (20) @(posedge ref_clk);
        por <= 1;
        run(222, 240, 8'hD2);
        wb(1, 12'hFF0, 8'hFF);
        flags("power on", 8'h80);
        wb(0, 12'h000, 0);
        chk(rd, 8'h00);
        wb(1, 12'hFFC, 1);
        run(222, 232, 8'hCE);
        flags("debugger", 8'h80);
        xt <= 1;
        wb(1, 12'hFFC, 1);
        run(176, 190, 8'hCE);
        xt <= 0;
        flags("crystal", 8'h80);
        wb(1, 12'hFF8, 8'h01);
        wb(0, 12'hFF8, 0);
        chk(rd, 8'h01);
        wdr <= 1;
        pulse();
        run(222, 232, 8'hCE);
        wb(0, 12'hFF8, 0);
        chk(rd, 8'h00);
        flags("watchdog", 8'h20);
        wb(1, 12'hFF8, 8'h01);
        stp <= 1;
        gp <= 8'h01;
        run(222, 232, 8'h66);
        stp <= 0;
        flags("gpio recovery", 8'h40);
        stp <= 1;
        pulse();
        run(222, 232, 8'h66);
        flags("watchdog recovery", 8'h60);
        fork hold(5, 0); run(222, 240, 8'hCE); join
        stp <= 0;
        flags("debug pin", 8'h80);
        hold(2, 1);
        repeat (20) @(posedge ref_clk);
        chk(cpu_reset, 1'b0);
        alt <= 0;
        hold(4, 1);
        repeat (20) @(posedge ref_clk);
        chk(cpu_reset, 1'b0);
        alt <= 1;
        fork hold(4, 1); run(222, 240, 8'hCE); join
        flags("pin", 8'h10);
        fork hold(400, 1); run(385, 410, 8'hCE); join
        flags("pin held", 8'h10);
        fork begin bor <= 0; repeat (10) @(posedge ref_clk); bor <= 1; end
            run(232, 255, 8'hDE); join
        flags("brownout", 8'h80);
        fork begin wb(1, 12'hFFC, 1); repeat (100) @(posedge ref_clk); wb(1, 12'hFFC, 1); end
            run(322, 340, 8'hCE); join
        flags("restart", 8'h80);
        chk(nf, 11);
        chk(nb, 0);
        end_of_test();
    end
endmodule
